// file: hw/ptsram_core.sv
// Pipelined turnaround-free SRAM core: 256K x 18 array, two-cycle data pipeline,
// 2-bit burst counter, three selects, byte strobes, clock gate, write trace queue.
// Assumes the controller shares clk_sys and presents all inputs synchronously.
//
// How it works
// RULE_01 - Advance high increments burst counter, no load.
// RULE_02 - Bursts ignore direction input, keep loaded direction.
// RULE_03 - Controller sets direction on first burst address.
// RULE_04 - Load with a false select deselects.
// RULE_05 - Data pins float two cycles after deselect.
// RULE_06 - Selected only when all three selects true.
// RULE_07 - Clock gate high blocks the edge entirely; here the trace queue's pop side still runs.
// RULE_08 - Suspended cycles hold every register and pin; here the trace queue's pop side and its output pins still move.
// RULE_09 - Data pins float after the first edge.
// RULE_10 - Each active-low strobe writes its own lane.
// RULE_11 - Several strobes together write several lanes.
// RULE_12 - Only two lane strobes exist here.
// RULE_13 - Order high steps start XOR count.
// RULE_14 - Order low steps start plus count modulo four.
// RULE_15 - Counter wraps to start and keeps counting.
// RULE_16 - Read data driven two cycles after load.
// RULE_17 - Write data arrives two cycles after address.
// RULE_18 - Advance after deselect is a no-op, floating.
// RULE_19 - Reads and writes follow back to back.
`timescale 1ns/1ps
`include "ptsram_consts.svh"

module ptsram_core (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   pipeline_hold_n,
   input  wire logic                   advance_or_load,
   input  wire logic                   read_not_write,
   input  wire ptsram_pkg::ptsram_addr_t address,
   input  wire logic                   select_low_a,
   input  wire logic                   select_low_b,
   input  wire logic                   select_high,
   input  wire logic                   byte_strobe_lane0_n,
   input  wire logic                   byte_strobe_lane1_n,
   input  wire logic                   burst_order_select,
   input  wire ptsram_pkg::ptsram_data_t data_in,
   output ptsram_pkg::ptsram_data_t    data_out,
   output logic                        data_oe,
   output logic                        trace_valid,
   input  wire logic                   trace_ready,
   output ptsram_pkg::ptsram_trace_t   trace_data,
   output logic                        trace_room,
   output logic                        trace_overflow
);

   import ptsram_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Next beat address bits: interleaved XOR or linear add, both wrap modulo four.
   function automatic ptsram_cnt_t burst_bits(input ptsram_cnt_t start,
                                              input ptsram_cnt_t cnt,
                                              input logic        interleaved);
      ptsram_cnt_t r;
      r = '0;
      if (interleaved) begin
         r = start ^ cnt; // RULE_13
      end else begin
         r = start + cnt; // RULE_14
      end
      return r;
   endfunction

   // Lane mask from the active-low strobes; only two lanes exist in this width.
   function automatic ptsram_data_t lane_mask(input ptsram_strobe_t strobe_n);
      ptsram_data_t m;
      m = '0;
      if (!strobe_n[0]) begin
         m[`PTS_LANE0_MSB:`PTS_LANE0_LSB] = 8'hff; // RULE_10
         m[`PTS_EXTRA0_BIT]               = 1'h1;  // RULE_10
      end
      if (!strobe_n[1]) begin
         m[`PTS_LANE1_MSB:`PTS_LANE1_LSB] = 8'hff; // RULE_10
         m[`PTS_EXTRA1_BIT]               = 1'h1;  // RULE_10
      end
      return m; // RULE_11
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   ptsram_data_t    mem_reg [`PTS_WORDS];
   ptsram_burst_e   burst_reg;
   ptsram_addr_t    base_reg;
   ptsram_cnt_t     cnt_reg;
   logic            s1_valid_reg;
   logic            s1_read_reg;
   ptsram_addr_t    s1_addr_reg;
   ptsram_strobe_t  s1_strobe_reg;
   logic            s2_write_reg;
   ptsram_addr_t    s2_addr_reg;
   ptsram_strobe_t  s2_strobe_reg;
   ptsram_data_t    dout_reg;
   logic            oe_reg;
   logic            overflow_reg;

   logic            edge_en;
   logic            selected;
   logic            do_load;
   logic            do_advance;
   ptsram_cnt_t     cnt_next;
   ptsram_addr_t    beat_addr;
   ptsram_strobe_t  strobe_n;
   ptsram_data_t    wr_mask;
   ptsram_data_t    wr_merged;
   ptsram_data_t    rd_word;
   ptsram_trace_t   trace_word;
   logic            trace_push;
   logic            fifo_in_ready;

   ////////////////////////////////////////////////////////////////////////////////
   // Cycle decode.

   // A high clock gate blocks the edge: every register below is enabled by this, except the trace queue's pop side.
   assign edge_en    = !pipeline_hold_n; // RULE_07

   // All three selects must be true; any single false one deselects.
   assign selected   = !select_low_a && !select_low_b && select_high; // RULE_06

   // A load needs advance low and a selected device; low with a false select deselects.
   assign do_load    = edge_en && !advance_or_load && selected; // RULE_04

   // An advance only continues a live burst; after a deselect it is a no-op.
   assign do_advance = edge_en && advance_or_load && (burst_reg != PTS_IDLE); // RULE_01 RULE_18

   // The counter simply rolls over, so the fifth beat is the loaded start again.
   assign cnt_next   = cnt_reg + ptsram_cnt_t'(1); // RULE_15

   // Address used this cycle: external on a load, counter-stepped on an advance.
   assign beat_addr  = do_load ? address
                     : {base_reg[`PTS_ADDR_W-1:`PTS_BURST_W],
                        burst_bits(base_reg[`PTS_BURST_W-1:0], cnt_next, burst_order_select)};

   // Only the two strobes of this width are sampled.
   assign strobe_n   = {byte_strobe_lane1_n, byte_strobe_lane0_n}; // RULE_12

   ////////////////////////////////////////////////////////////////////////////////
   // Burst state: direction, base address and beat counter.

   // Direction is latched only at a load; during advances the input is not looked at.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         burst_reg <= PTS_IDLE;
         base_reg  <= '0;
         cnt_reg   <= `PTS_BURST_START;
      end else if (edge_en) begin
         if (do_load) begin
            burst_reg <= read_not_write ? PTS_READ : PTS_WRITE; // RULE_02 RULE_03
            base_reg  <= address;
            cnt_reg   <= `PTS_BURST_START;
         end else if (!advance_or_load) begin
            burst_reg <= PTS_IDLE; // RULE_04
         end else if (do_advance) begin
            cnt_reg   <= cnt_next; // RULE_01 RULE_15
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pipeline stage one: the operation sampled at this edge.

   // Deselects and no-ops enter as empty slots, so pending transfers still finish.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s1_valid_reg  <= 1'h0;
         s1_read_reg   <= 1'h0;
         s1_addr_reg   <= '0;
         s1_strobe_reg <= 2'h3;
      end else if (edge_en) begin
         s1_valid_reg  <= do_load || do_advance; // RULE_04 RULE_18
         s1_addr_reg   <= beat_addr;
         s1_strobe_reg <= strobe_n;
         if (do_load) begin
            s1_read_reg <= read_not_write;
         end else begin
            s1_read_reg <= (burst_reg == PTS_READ); // RULE_02
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pipeline stage two: writes waiting for their data on the pins.

   // A write commits one edge after stage two, so its data arrives two cycles late.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s2_write_reg  <= 1'h0;
         s2_addr_reg   <= '0;
         s2_strobe_reg <= 2'h3;
      end else if (edge_en) begin
         s2_write_reg  <= s1_valid_reg && !s1_read_reg; // RULE_17
         s2_addr_reg   <= s1_addr_reg;
         s2_strobe_reg <= s1_strobe_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Array write and read with forwarding.

   // Merge the pin data into the stored word lane by lane.
   assign wr_mask   = lane_mask(s2_strobe_reg);
   assign wr_merged = (data_in & wr_mask) | (mem_reg[s2_addr_reg] & ~wr_mask);

   // A read sampled one cycle after a write to the same word sees that write, since
   // both happen at one edge; forwarding is what lets the directions alternate freely.
   assign rd_word   = (s2_write_reg && (s2_addr_reg == s1_addr_reg))
                    ? wr_merged : mem_reg[s1_addr_reg]; // RULE_19

   // The array takes the data present on the pins two cycles after the address.
   always_ff @(posedge clk_sys) begin
      if (edge_en && s2_write_reg) begin
         mem_reg[s2_addr_reg] <= wr_merged; // RULE_10 RULE_11 RULE_17
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data pins.

   // The driver is enabled for the cycle two after a read; writes, deselects and
   // no-ops leave it off. A suspended edge leaves value and enable untouched.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dout_reg <= `PTS_DOUT_RESET;
         oe_reg   <= `PTS_OE_RESET; // RULE_09
      end else if (edge_en) begin
         oe_reg <= s1_valid_reg && s1_read_reg; // RULE_05 RULE_16 RULE_18 RULE_19
         if (s1_valid_reg && s1_read_reg) begin
            dout_reg <= rd_word; // RULE_16
         end
      end
   end // RULE_08

   assign data_out = dout_reg;
   assign data_oe  = oe_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Write trace: each committed write is reported as {strobes, address, data}.

   // The trace cannot stall the memory pins, so a write that finds the queue full is
   // dropped from the trace and flagged; trace_room warns the consumer beforehand.
   assign trace_word = {s2_strobe_reg, s2_addr_reg, data_in};
   assign trace_push = edge_en && s2_write_reg;

   ptsram_fifo #(
      .WIDTH (`PTS_TRACE_W),
      .DEPTH (`PTS_TRACE_DEPTH)
   ) u_trace_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (trace_push),
      .in_ready  (fifo_in_ready),
      .in_data   (trace_word),
      .out_valid (trace_valid),
      .out_ready (trace_ready),
      .out_data  (trace_data)
   );

   assign trace_room = fifo_in_ready;

   // Sticky overflow, cleared only by reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         overflow_reg <= 1'h0;
      end else if (trace_push && !fifo_in_ready) begin
         overflow_reg <= 1'h1;
      end
   end

   assign trace_overflow = overflow_reg;

endmodule

// file: shared/ptsram_consts.svh
// Constants for the pipelined turnaround-free SRAM core: widths, lane layout, reset values.
// Assumes it is included by bare name from the package and the design files.
`ifndef PTSRAM_CONSTS_SVH
`define PTSRAM_CONSTS_SVH

// Array geometry: 256K words of 18 bits.
`define PTS_ADDR_W        18
`define PTS_DATA_W        18
`define PTS_WORDS         262144

// Lane layout of a data word.
`define PTS_LANE0_LSB     0
`define PTS_LANE0_MSB     7
`define PTS_LANE1_LSB     8
`define PTS_LANE1_MSB     15
`define PTS_EXTRA0_BIT    16
`define PTS_EXTRA1_BIT    17
`define PTS_LANES         2

// Burst counter width and its value at a load.
`define PTS_BURST_W       2
`define PTS_BURST_START   2'h0

// Write trace queue geometry.
`define PTS_TRACE_DEPTH   32
`define PTS_TRACE_W       38

// Reset values of the data pins.
`define PTS_DOUT_RESET    18'h00000
`define PTS_OE_RESET      1'h0

`endif

// file: shared/ptsram_pkg.sv
// Types shared by the pipelined turnaround-free SRAM core and its trace queue.
// Assumes ptsram_consts.svh is on the include path.
`include "ptsram_consts.svh"

package ptsram_pkg;

   // Direction latched for the running burst; idle after a deselect.
   typedef enum logic [1:0] {
      PTS_IDLE  = 2'b00,
      PTS_READ  = 2'b01,
      PTS_WRITE = 2'b10
   } ptsram_burst_e;

   typedef logic [`PTS_ADDR_W-1:0]  ptsram_addr_t;
   typedef logic [`PTS_DATA_W-1:0]  ptsram_data_t;
   typedef logic [`PTS_BURST_W-1:0] ptsram_cnt_t;
   typedef logic [`PTS_LANES-1:0]   ptsram_strobe_t;
   typedef logic [`PTS_TRACE_W-1:0] ptsram_trace_t;

endpackage

// file: hw/ptsram_fifo.sv
// Flip-flop FIFO with valid/ready on both sides, parameterised in width and depth.
// Assumes one clock and a synchronous active-high reset; DEPTH is a power of two.
`timescale 1ns/1ps

module ptsram_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 32
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW-1:0]    rd_ptr_next;
   logic [PW:0]      count_reg;
   logic [PW:0]      count_next;
   logic             in_ready_reg;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic             push;
   logic             pop;

   // Flags and head word are registered, so every port comes straight from a flip-flop.
   assign in_ready    = in_ready_reg;
   assign out_valid   = out_valid_reg;
   assign out_data    = out_data_reg;
   assign push        = in_valid && in_ready_reg;
   assign pop         = out_valid_reg && out_ready;
   assign rd_ptr_next = pop ? rd_ptr_reg + PW'(1) : rd_ptr_reg;

   // Occupancy after this edge; the flags are taken from it, so neither can lie.
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + (PW+1)'(1);
      end else if (pop && !push) begin
         count_next = count_reg - (PW+1)'(1);
      end
   end

   // Head word for the next cycle; a push into a queue left empty goes straight through.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         out_data_reg <= '0;
      end else if (push && (rd_ptr_next == wr_ptr_reg)) begin
         out_data_reg <= in_data;
      end else begin
         out_data_reg <= store_reg[rd_ptr_next];
      end
   end

   // Storage is written only on an accepted push.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers, count and flags; simultaneous push and pop keep the count.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         count_reg     <= '0;
         in_ready_reg  <= 1'h1;
         out_valid_reg <= 1'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + PW'(1);
         end
         rd_ptr_reg    <= rd_ptr_next;
         count_reg     <= count_next;
         in_ready_reg  <= (count_next != (PW+1)'(DEPTH));
         out_valid_reg <= (count_next != '0);
      end
   end

endmodule

// file: test/ptsram_core_monitor.sv
// Checker for the SRAM core: data pipe timing, deselect, no-op, suspend and trace flags.
// Assumes one clock domain whose synchronous active-high reset is rst.
`timescale 1ns/1ps
module ptsram_core_monitor (
   input wire logic                     clk_sys,
   input wire logic                     rst,
   input wire logic                     pipeline_hold_n,
   input wire logic                     advance_or_load,
   input wire logic                     read_not_write,
   input wire logic                     select_low_a,
   input wire logic                     select_low_b,
   input wire logic                     select_high,
   input wire ptsram_pkg::ptsram_data_t data_out,
   input wire logic                     data_oe,
   input wire logic                     trace_valid,
   input wire logic                     trace_room,
   input wire logic                     trace_overflow
);
   import ptsram_pkg::*;
   ////////////////////////////////////////
   // One domain, so clock and reset stand once for every property.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire sel_ok = !select_low_a && !select_low_b && select_high;
   // Steps of a request; an edge only counts while the clock gate is open.
   sequence s_live; !pipeline_hold_n; endsequence
   sequence s_adv; !pipeline_hold_n && advance_or_load; endsequence
   sequence s_desel; !pipeline_hold_n && !advance_or_load && !sel_ok; endsequence
   sequence s_load(rd);
      !pipeline_hold_n && !advance_or_load && sel_ok && read_not_write == rd;
   endsequence
   ////////////////////////////////////////
   a_read_two_later: assert property (s_load(1'b1) ##1 s_live |=> data_oe)
      else $error("read data not driven two live edges after its load");
   a_desel_float: assert property (s_desel ##1 s_live |=> !data_oe)
      else $error("data pins still driven two live edges after a deselect");
   a_noop_float: assert property (s_desel ##1 s_adv ##1 s_live |=> !data_oe)
      else $error("data pins driven after a no-op");
   a_burst_dir_kept: assert property
      (s_load(1'b1) ##1 (s_adv ##0 !read_not_write) ##1 s_live |=> data_oe)
      else $error("read burst lost its direction on an advance");
   a_write_no_drive: assert property (s_load(1'b0) ##1 s_live |=> !data_oe)
      else $error("data pins driven for a write");
   a_back_to_back: assert property (s_load(1'b0) ##1 s_load(1'b1) ##1 s_live |=> data_oe)
      else $error("read right after a write was not driven in time");
   a_suspend_hold: assert property (pipeline_hold_n |=> $stable(data_oe) && $stable(data_out))
      else $error("data pins changed on a gated edge");
   a_oe_after_reset: assert property ($fell(rst) |-> !data_oe)
      else $error("data pins driven right after reset");
   a_overflow_sticky: assert property (trace_overflow |=> trace_overflow)
      else $error("trace overflow flag cleared without reset");
   a_full_not_empty: assert property (!trace_room |-> trace_valid)
      else $error("trace queue full but shows no item");
endmodule

bind ptsram_core ptsram_core_monitor u_mon (.*);

// file: test/ptsram_ctrl_model.sv
// Controller model: drives the core's request pins and write data, pops the trace queue.
// Assumes the bench calls cyc once per clock and that clk_sys is shared with the core.
`timescale 1ns/1ps
module ptsram_ctrl_model (
   input  wire logic                clk_sys,
   input  wire logic                stall_pop,
   output logic                     trace_ready,
   output logic                     pipeline_hold_n,
   output logic                     advance_or_load,
   output logic                     read_not_write,
   output ptsram_pkg::ptsram_addr_t address,
   output logic                     select_low_a,
   output logic                     select_low_b,
   output logic                     select_high,
   output logic                     byte_strobe_lane0_n,
   output logic                     byte_strobe_lane1_n,
   output logic                     burst_order_select,
   output ptsram_pkg::ptsram_data_t data_in
);
   import ptsram_pkg::*;
   ptsram_data_t d1;
   ptsram_data_t d2;
   ////////////////////////////////////////
   // Idle pins from time zero: a deselected load with the gate open.
   initial begin
      {pipeline_hold_n, advance_or_load, read_not_write, address} = '0;
      {select_low_a, select_low_b, select_high} = 3'h6;
      {byte_strobe_lane1_n, byte_strobe_lane0_n, burst_order_select} = 3'h6;
      {d1, d2, data_in, trace_ready} = '0;
   end
   // One request per call, launched after the edge so the core takes it at the next one.
   task automatic cyc(input logic hold_n, adv, rw, input ptsram_addr_t a,
                      input logic [2:0] sel, input ptsram_strobe_t stb, input logic ord,
                      input ptsram_data_t wd);
      @(posedge clk_sys);
      pipeline_hold_n <= hold_n;
      advance_or_load <= adv;
      read_not_write <= rw;
      address <= a;
      {select_low_a, select_low_b, select_high} <= sel;
      {byte_strobe_lane1_n, byte_strobe_lane0_n} <= stb;
      burst_order_select <= ord;
      // Data trails its beat by two live edges; a gated edge moves nothing.
      if (!hold_n) begin
         data_in <= d2;
         d2 = d1;
         d1 = wd;
      end
   endtask
   // Pops every other cycle unless stalled, so the queue meets slow and blocked readers.
   always @(posedge clk_sys) begin
      trace_ready <= !stall_pop && !trace_ready;
   end
endmodule

// file: test/ptsram_core_tb.sv
// Self-checking bench for the SRAM core: bursts, strobes, selects, suspend, trace queue.
// Assumes the core, its package, the controller model and the checker are compiled first.
`timescale 1ns/1ps
`include "ptsram_consts.svh"
module ptsram_core_tb;
   import ptsram_pkg::*;
   logic clk_sys, rst, stall_pop, trace_ready, pipeline_hold_n, advance_or_load;
   logic read_not_write, select_low_a, select_low_b, select_high, byte_strobe_lane0_n;
   logic byte_strobe_lane1_n, burst_order_select, data_oe, trace_valid, trace_room;
   logic trace_overflow, live, dir, s_v, s_rd, e_oe, e_ovf, p_hold, p_adv, p_rw, p_ord;
   logic [2:0]     p_sel;
   ptsram_addr_t   address, base, s_a, p_a;
   ptsram_data_t   data_in, data_out, s_wd, p_wd, e_q;
   ptsram_strobe_t s_stb, p_stb;
   ptsram_cnt_t    cnt;
   ptsram_trace_t  trace_data;
   ptsram_data_t   mem [ptsram_addr_t];
   ptsram_trace_t  tq [$];
   int             n_errors, checked, i;
   ptsram_core dut (.*);
   ptsram_ctrl_model ctl (.*);
   ////////////////////////////////////////
   // Free-running 125 MHz clock.
   initial clk_sys = 1'b0;
   always #4 clk_sys = ~clk_sys;
   task automatic chk(input logic [37:0] got, input logic [37:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // One request, then the pins checked against the request retired by the edge just past.
   task automatic op(input logic h, ad, r, input ptsram_addr_t a, input logic [2:0] sel,
                     input ptsram_strobe_t stb, input logic o, input ptsram_data_t wd);
      ptsram_data_t m;
      ctl.cyc(h, ad, r, a, sel, stb, o, wd);
      #1;
      if (!p_hold) begin
         e_oe = s_v && s_rd;
         m = {!s_stb[1], !s_stb[0], {8{!s_stb[1]}}, {8{!s_stb[0]}}};
         if (s_v && !s_rd) begin
            mem[s_a] = ((mem.exists(s_a) ? mem[s_a] : 18'h0) & ~m) | (s_wd & m);
            if (tq.size() < `PTS_TRACE_DEPTH) tq.push_back({s_stb, s_a, s_wd});
            else e_ovf = 1'b1;
         end
         if (e_oe) e_q = mem[s_a];
         if (!p_adv && p_sel == 3'h1) {live, dir, base, cnt} = {1'b1, p_rw, p_a, 2'h0};
         else if (!p_adv || !live) live = 1'b0;
         else cnt++;
         {s_v, s_rd, s_stb, s_wd} = {live, dir, p_stb, p_wd};
         s_a = {base[17:2], p_ord ? base[1:0] ^ cnt : base[1:0] + cnt};
      end
      chk(data_oe, e_oe);
      if (e_oe) chk(data_out, e_q);
      {p_hold, p_adv, p_rw, p_a, p_sel, p_stb, p_ord, p_wd} = {h, ad, r, a, sel, stb, o, wd};
   endtask
   // A load then advances that carry the opposite direction, which must be ignored.
   task automatic burst(input logic r, input ptsram_addr_t a, input logic o, input int n);
      op(1'b0, 1'b0, r, a, 3'h1, 2'h0, o, 18'h3a500 ^ a);
      for (int k = 1; k < n; k++)
         op(1'b0, 1'b1, !r, '0, 3'h1, 2'h0, o, 18'h0c5a0 + 18'(k));
   endtask
   task automatic dsl();
      repeat (2) op(1'b0, 1'b0, 1'b1, '0, 3'h6, 2'h3, 1'b0, 18'h2aaaa);
   endtask
   task automatic drain();
      int k;
      for (k = 0; k < 300 && (trace_valid !== 1'b0 || tq.size() != 0); k++) @(posedge clk_sys);
      if (k >= 300) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, tq.size(), 0);
         give_verdict();
      end
   endtask
   // Every popped trace item must match the oldest logged write.
   always @(posedge clk_sys) begin
      if (!rst && trace_valid === 1'b1 && trace_ready === 1'b1)
         chk(trace_data, tq.size() ? tq.pop_front() : ~trace_data);
   end
   ////////////////////////////////////////
   initial begin
      {rst, stall_pop, p_hold, live, s_v, e_oe, e_ovf} = 7'h40;
      {n_errors, checked} = '0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      // Linear then interleaved bursts, read back from another start and past the wrap.
      for (i = 0; i < 2; i++) begin
         burst(1'b0, (18'h100 << i) | 18'h1, i[0], 4);
         burst(1'b1, (18'h100 << i) | 18'h3, i[0], 6);
         dsl();
      end
      // Gated edges in mid read burst freeze the pipe.
      op(1'b0, 1'b0, 1'b1, 18'h100, 3'h1, 2'h3, 1'b0, '1);
      op(1'b0, 1'b1, 1'b1, '0, 3'h1, 2'h3, 1'b0, '1);
      repeat (3) op(1'b1, 1'b1, 1'b0, '0, 3'h6, 2'h3, 1'b0, '0);
      repeat (2) op(1'b0, 1'b1, 1'b1, '0, 3'h1, 2'h3, 1'b0, '1);
      dsl();
      // Every strobe pair in turn, ending on a full write, then a read right behind it,
      // which only sees the new word if the merged data is forwarded.
      for (i = 0; i < 4; i++)
         op(1'b0, 1'b0, 1'b0, 18'h100, 3'h1, ~i[1:0], 1'b0, 18'(18'h11111 * (i + 1)));
      op(1'b0, 1'b0, 1'b1, 18'h100, 3'h1, 2'h3, 1'b0, '1);
      dsl();
      // Each select pattern on a load, then an advance that is a no-op unless selected.
      for (i = 0; i < 8; i++) begin
         op(1'b0, 1'b0, 1'b1, 18'h100, i[2:0], 2'h3, 1'b0, '1);
         op(1'b0, 1'b1, 1'b1, '0, 3'h6, 2'h3, 1'b0, '1);
      end
      dsl();
      drain();
      // Blocked reader: the trace queue fills, refuses one write and flags it.
      stall_pop <= 1'b1;
      for (i = 0; i <= 32; i++) op(1'b0, 1'b0, 1'b0, 18'h300 + i[17:0], 3'h1, 2'h0, 1'b0, i[17:0]);
      dsl();
      dsl();
      chk(trace_room, 1'b0);
      chk(trace_overflow, e_ovf);
      stall_pop <= 1'b0;
      drain();
      give_verdict();
   end
endmodule
